// [shared/fsp_defines.svh]
// offsets, field positions, reset values and widths for the flash self-program protection block
// assumes a 32-bit apb register window with one aligned word per register
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// ==========================================================================
// register byte offsets
`define FSP_OFF_LOCK        12'h000
`define FSP_OFF_PTR_EXT     12'h004
`define FSP_OFF_CFG         12'h008
`define FSP_OFF_STATUS      12'h00c
`define FSP_OFF_TARGET      12'h010
`define FSP_OFF_RESET_VEC   12'h014

// ==========================================================================
// lock field bit positions inside the lock register
`define FSP_APP_LO_BIT      0
`define FSP_APP_HI_BIT      1
`define FSP_BOOT_LO_BIT     2
`define FSP_BOOT_HI_BIT     3

// ==========================================================================
// status bit positions
`define FSP_ST_APP_WR_BIT   0
`define FSP_ST_APP_RD_BIT   1
`define FSP_ST_BOOT_WR_BIT  2
`define FSP_ST_BOOT_RD_BIT  3
`define FSP_ST_APP_SPM_BIT  4
`define FSP_ST_BUSY_BIT     5

// ==========================================================================
// reset values and sizes
`define FSP_LOCK_ERASED     4'hf
`define FSP_PTR_EXT_RST     8'h00
`define FSP_APP_RESET_WORD  23'h000000
`define FSP_EXT_THRESHOLD   32'h00010000
`define FSP_INIT_WAIT       2'h2

`endif

// [shared/fsp_pkg.sv]
// types for the flash self-program protection block
// assumes fsp_defines.svh supplies the numeric constants
package fsp_pkg;

	typedef enum logic [0:0] {
		FSP_IDLE,
		FSP_BUSY
	} fsp_state_e;

	typedef struct packed {
		fsp_state_e  state;
		logic [3:0]  lock;
		logic [7:0]  ptr_ext;
		logic        ivt_boot;
		logic [22:0] tgt_word;
		logic [23:0] rd_addr;
		logic        byte_sel;
		logic        lpm_grant;
		logic        lpm_deny;
		logic        spm_grant;
		logic        spm_deny;
		logic        irq_sup;
		logic [22:0] rst_vec;
		logic [4:0]  viol;
		logic [31:0] prdata;
		logic        fuse_s1;
		logic        fuse_s2;
		logic [3:0]  nvl_s1;
		logic [3:0]  nvl_s2;
		logic [1:0]  init_cnt;
		logic        loaded;
	} fsp_state_s;

endpackage

// [src/fsp_top.sv]
// flash self-program protection: lock checking, interrupt masking, reset vector, addressing
// assumes cpu strobes are on pclk; fuse and stored lock bits arrive from another domain
//
// Summary of operation
// [RULE1] locks only programmed; chip erase clears them
// [RULE2] general write lock ignored for spm
// [RULE3] general read/write lock ignored for lpm/spm
// [RULE4] app locks 11: app access unrestricted
// [RULE5] app locks 10: block spm writes to app
// [RULE6] app locks 00: block writes, boot reads
// [RULE7] app locks 01: block boot reads, allow writes
// [RULE8] app read-blocking: mask irqs in app
// [RULE9] boot locks 11: boot access unrestricted
// [RULE10] boot locks 10: block spm writes to boot
// [RULE11] boot locks 00: block writes, app reads
// [RULE12] boot locks 01: block app reads, allow writes
// [RULE13] boot read-blocking: mask irqs in boot
// [RULE14] reset vector from boot reset fuse
// [RULE15] cpu cannot alter any fuse
// [RULE16] 24-bit pointer: extension plus high, low
// [RULE17] extension register only above 64k bytes
// [RULE18] low bits word index, high bits page
// [RULE19] target address latched at operation start
// [RULE20] software uses same page for erase, write
// [RULE21] lpm addresses bytes, bit 0 selects byte
// [RULE22] classify pc and target by section
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ns

`include "fsp_defines.svh"

module fsp_top
	import fsp_pkg::*;
#(
	parameter logic [22:0] BOOT_START_WORD  = 23'h01f000,
	parameter int          PAGE_WORD_BITS   = 7,
	parameter logic [31:0] PROG_SPACE_BYTES = 32'h00040000
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic [22:0]                cpu_pc,
	input  wire logic                       load_program_memory_instr,
	input  wire logic                       store_program_memory_instr,
	input  wire logic [7:0]                 pointer_high_byte,
	input  wire logic [7:0]                 pointer_low_byte,
	input  wire logic                       flash_op_done,
	input  wire logic                       boot_reset_select_fuse,
	input  wire logic [3:0]                 stored_lock_bits,
	input  wire logic                       prog_if_lock_wr,
	input  wire logic [3:0]                 prog_if_lock_data,
	input  wire logic                       prog_if_chip_erase,
	output logic                            lpm_grant,
	output logic                            lpm_deny,
	output logic [23:0]                     lpm_byte_addr,
	output logic                            byte_select_bit,
	output logic                            spm_grant,
	output logic                            spm_deny,
	output logic                            spm_busy,
	output logic [22:0]                     spm_word_addr,
	output logic [22-PAGE_WORD_BITS:0]      spm_page_num,
	output logic [PAGE_WORD_BITS-1:0]       spm_word_index,
	output logic                            irq_suppress,
	output logic [22:0]                     reset_vector,
	output logic [3:0]                      lock_bits
);

	// ==========================================================================
	// constants and helpers
	localparam logic EXT_IMPL = (PROG_SPACE_BYTES > `FSP_EXT_THRESHOLD); // [RULE17]

	// section of a word address
	function automatic logic in_boot(input logic [22:0] word_addr);
		in_boot = (word_addr >= BOOT_START_WORD); // [RULE22]
	endfunction

	// register offset decode
	function automatic logic is_mapped(input logic [11:0] addr);
		case (addr)
			`FSP_OFF_LOCK,
			`FSP_OFF_PTR_EXT,
			`FSP_OFF_CFG,
			`FSP_OFF_STATUS,
			`FSP_OFF_TARGET,
			`FSP_OFF_RESET_VEC: is_mapped = 1'b1;
			default:            is_mapped = 1'b0;
		endcase
	endfunction

	// ==========================================================================
	// state
	fsp_state_s st_reg;
	fsp_state_s st_next;

	logic        apb_wr;
	logic        apb_setup;
	logic [23:0] ptr24;
	logic [22:0] ptr_word;
	logic        pc_boot;
	logic        tgt_boot;
	logic        app_rd_lock;
	logic        app_wr_lock;
	logic        boot_rd_lock;
	logic        boot_wr_lock;
	logic        lpm_block;
	logic        spm_block;
	logic [4:0]  viol_set;
	logic [31:0] rd_value;

	// ==========================================================================
	// combinational next state
	always_comb begin
		st_next = st_reg;

		// one-cycle strobes
		st_next.lpm_grant = 1'b0;
		st_next.lpm_deny  = 1'b0;
		st_next.spm_grant = 1'b0;
		st_next.spm_deny  = 1'b0;

		// synchronisers for out-of-domain levels
		st_next.fuse_s1 = boot_reset_select_fuse;
		st_next.fuse_s2 = st_reg.fuse_s1;
		st_next.nvl_s1  = stored_lock_bits;
		st_next.nvl_s2  = st_reg.nvl_s1;

		// stored lock bits taken once synchronised values are stable
		if (!st_reg.loaded) begin
			if (st_reg.init_cnt == `FSP_INIT_WAIT) begin
				st_next.lock   = st_reg.nvl_s2;
				st_next.loaded = 1'b1;
			end else begin
				st_next.init_cnt = st_reg.init_cnt + 2'h1;
			end
		end

		// reset vector follows the fuse; cpu has no path to change it
		st_next.rst_vec = st_reg.fuse_s2 ? `FSP_APP_RESET_WORD : BOOT_START_WORD; // [RULE14] [RULE15]

		// pointer and section classification
		ptr24    = {(EXT_IMPL ? st_reg.ptr_ext : 8'h00), pointer_high_byte, pointer_low_byte}; // [RULE16]
		ptr_word = ptr24[23:1];
		pc_boot  = in_boot(cpu_pc);   // [RULE22]
		tgt_boot = in_boot(ptr_word); // [RULE22]

		// lock decode; the general lock bits are not inputs here at all
		app_wr_lock  = !st_reg.lock[`FSP_APP_LO_BIT];  // [RULE4] [RULE5] [RULE6] [RULE7] [RULE2]
		app_rd_lock  = !st_reg.lock[`FSP_APP_HI_BIT];  // [RULE4] [RULE6] [RULE7] [RULE3]
		boot_wr_lock = !st_reg.lock[`FSP_BOOT_LO_BIT]; // [RULE9] [RULE10] [RULE11] [RULE12]
		boot_rd_lock = !st_reg.lock[`FSP_BOOT_HI_BIT]; // [RULE9] [RULE11] [RULE12]

		// interrupt masking by section of execution
		st_next.irq_sup = (app_rd_lock && st_reg.ivt_boot && !pc_boot)    // [RULE8]
		               || (boot_rd_lock && !st_reg.ivt_boot && pc_boot); // [RULE13]

		// load program memory check
		lpm_block = (tgt_boot && !pc_boot && boot_rd_lock)  // [RULE11] [RULE12]
		         || (!tgt_boot && pc_boot && app_rd_lock); // [RULE6] [RULE7]

		// store program memory check; only boot code may program
		spm_block = !pc_boot
		         || (tgt_boot && boot_wr_lock)  // [RULE10] [RULE11]
		         || (!tgt_boot && app_wr_lock); // [RULE5] [RULE6]

		viol_set = 5'h00;

		if (load_program_memory_instr) begin
			st_next.rd_addr  = ptr24;    // [RULE21]
			st_next.byte_sel = ptr24[0]; // [RULE21]
			st_next.lpm_grant = !lpm_block;
			st_next.lpm_deny  = lpm_block;
			viol_set[`FSP_ST_APP_RD_BIT]  = lpm_block && !tgt_boot;
			viol_set[`FSP_ST_BOOT_RD_BIT] = lpm_block && tgt_boot;
		end

		case (st_reg.state)
			FSP_IDLE: begin
				if (store_program_memory_instr) begin
					if (spm_block) begin
						st_next.spm_deny = 1'b1;
						viol_set[`FSP_ST_APP_SPM_BIT] = !pc_boot;
						viol_set[`FSP_ST_APP_WR_BIT]  = pc_boot && !tgt_boot;
						viol_set[`FSP_ST_BOOT_WR_BIT] = pc_boot && tgt_boot;
					end else begin
						st_next.tgt_word  = ptr_word; // [RULE19]
						st_next.spm_grant = 1'b1;
						st_next.state     = FSP_BUSY;
					end
				end
			end
			FSP_BUSY: begin
				// pointer changes no longer reach the latched target
				if (store_program_memory_instr) begin
					st_next.spm_deny = 1'b1;
				end
				if (flash_op_done) begin
					st_next.state = FSP_IDLE;
				end
			end
			default: begin
				st_next.state = FSP_IDLE;
			end
		endcase

		// apb register access
		apb_setup = psel && !penable;
		apb_wr    = psel && penable && pwrite && is_mapped(paddr);

		case (paddr)
			`FSP_OFF_LOCK:      rd_value = {28'h0000000, st_reg.lock};
			`FSP_OFF_PTR_EXT:   rd_value = {24'h000000, (EXT_IMPL ? st_reg.ptr_ext : 8'h00)};
			`FSP_OFF_CFG:       rd_value = {30'h00000000, st_reg.fuse_s2, st_reg.ivt_boot};
			`FSP_OFF_STATUS:    rd_value = {26'h0000000, (st_reg.state == FSP_BUSY), st_reg.viol};
			`FSP_OFF_TARGET:    rd_value = {9'h000, st_reg.tgt_word};
			`FSP_OFF_RESET_VEC: rd_value = {9'h000, st_reg.rst_vec};
			default:            rd_value = 32'h00000000;
		endcase
		if (apb_setup && !pwrite) begin
			st_next.prdata = rd_value;
		end

		// sticky violations: a new event wins over a clear in the same cycle
		st_next.viol = st_reg.viol | viol_set;
		if (apb_wr && paddr == `FSP_OFF_STATUS) begin
			st_next.viol = (st_reg.viol & ~pwdata[4:0]) | viol_set;
		end

		if (apb_wr) begin
			case (paddr)
				`FSP_OFF_LOCK: begin
					// a zero programs a lock bit, a one leaves it alone
					st_next.lock = st_next.lock & pwdata[3:0]; // [RULE1]
				end
				`FSP_OFF_PTR_EXT: begin
					if (EXT_IMPL) begin
						st_next.ptr_ext = pwdata[7:0]; // [RULE17]
					end
				end
				`FSP_OFF_CFG: begin
					// fuse bit is read-only, writes to it are dropped
					st_next.ivt_boot = pwdata[0]; // [RULE15]
				end
				default: begin
					st_next.ptr_ext = st_next.ptr_ext;
				end
			endcase
		end

		// programming interface may program, only chip erase un-programs
		if (prog_if_lock_wr) begin
			st_next.lock = st_next.lock & prog_if_lock_data; // [RULE1]
		end
		if (prog_if_chip_erase) begin
			st_next.lock   = `FSP_LOCK_ERASED; // [RULE1]
			st_next.loaded = 1'b1;
		end
	end

	// ==========================================================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg          <= '0;
			st_reg.state    <= FSP_IDLE;
			st_reg.lock     <= `FSP_LOCK_ERASED;
			st_reg.ptr_ext  <= `FSP_PTR_EXT_RST;
			st_reg.rst_vec  <= `FSP_APP_RESET_WORD;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================================
	// outputs
	assign prdata          = st_reg.prdata;
	assign pready          = 1'b1;
	assign pslverr         = psel && penable && !is_mapped(paddr);
	assign lpm_grant       = st_reg.lpm_grant;
	assign lpm_deny        = st_reg.lpm_deny;
	assign lpm_byte_addr   = st_reg.rd_addr;
	assign byte_select_bit = st_reg.byte_sel;
	assign spm_grant       = st_reg.spm_grant;
	assign spm_deny        = st_reg.spm_deny;
	assign spm_busy        = (st_reg.state == FSP_BUSY);
	assign spm_word_addr   = st_reg.tgt_word;
	assign spm_page_num    = st_reg.tgt_word[22:PAGE_WORD_BITS];   // [RULE18]
	assign spm_word_index  = st_reg.tgt_word[PAGE_WORD_BITS-1:0];  // [RULE18]
	assign irq_suppress    = st_reg.irq_sup;
	assign reset_vector    = st_reg.rst_vec;
	assign lock_bits       = st_reg.lock;

endmodule // fsp_top

// [tb/fsp_monitor.sv]
// port checker for fsp_top
// assumes it is bound onto fsp_top and sees only its ports
`timescale 1ns/1ns
module fsp_monitor #(
	parameter logic [22:0] BOOT_START_WORD = 23'h01f000,
	parameter int          PAGE_WORD_BITS  = 7
) (
	input wire logic                      pclk,
	input wire logic                      presetn,
	input wire logic [22:0]               cpu_pc,
	input wire logic                      load_program_memory_instr,
	input wire logic                      store_program_memory_instr,
	input wire logic [7:0]                pointer_high_byte,
	input wire logic [7:0]                pointer_low_byte,
	input wire logic                      boot_reset_select_fuse,
	input wire logic                      prog_if_chip_erase,
	input wire logic                      lpm_grant,
	input wire logic                      lpm_deny,
	input wire logic [23:0]               lpm_byte_addr,
	input wire logic                      byte_select_bit,
	input wire logic                      spm_grant,
	input wire logic                      spm_deny,
	input wire logic                      spm_busy,
	input wire logic [22:0]               spm_word_addr,
	input wire logic [22-PAGE_WORD_BITS:0] spm_page_num,
	input wire logic [PAGE_WORD_BITS-1:0] spm_word_index,
	input wire logic                      irq_suppress,
	input wire logic [22:0]               reset_vector,
	input wire logic [3:0]                lock_bits
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ====
	// load requests by section of the issuing code
	sequence load_boot_s;
		load_program_memory_instr && cpu_pc >= BOOT_START_WORD;
	endsequence
	sequence load_app_s;
		load_program_memory_instr && cpu_pc < BOOT_START_WORD;
	endsequence
	// ====
	// assertions
	load_answer_a: assert property (
		load_program_memory_instr |=> lpm_grant ^ lpm_deny) else $error("load answer missing");
	store_answer_a: assert property (
		store_program_memory_instr |=> spm_grant ^ spm_deny) else $error("store answer missing");
	app_read_a: assert property (load_boot_s ##1
		lpm_byte_addr[23:1] < BOOT_START_WORD |-> lpm_deny == !$past(lock_bits[1]))
		else $error("app read gate wrong");
	boot_read_a: assert property (load_app_s ##1
		lpm_byte_addr[23:1] >= BOOT_START_WORD |-> lpm_deny == !$past(lock_bits[3]))
		else $error("boot read gate wrong");
	store_lock_a: assert property (spm_grant |-> $past(cpu_pc) >= BOOT_START_WORD &&
		(spm_word_addr >= BOOT_START_WORD ? $past(lock_bits[2]) : $past(lock_bits[0])))
		else $error("store granted against lock");
	busy_start_a: assert property (spm_grant |-> spm_busy && !$past(spm_busy))
		else $error("busy not tied to grant");
	addr_hold_a: assert property (spm_busy && !spm_grant |-> $stable(spm_word_addr))
		else $error("target moved while busy");
	page_split_a: assert property (spm_grant |->
		{spm_page_num, spm_word_index} == spm_word_addr &&
		spm_word_addr[14:0] == $past({pointer_high_byte, pointer_low_byte[7:1]}))
		else $error("page split wrong");
	byte_addr_a: assert property ($past(load_program_memory_instr) |->
		{lpm_byte_addr[15:0], byte_select_bit} ==
		$past({pointer_high_byte, pointer_low_byte, pointer_low_byte[0]}))
		else $error("load address wrong");
	reset_vec_a: assert property ($stable(boot_reset_select_fuse)[*4] |->
		reset_vector == (boot_reset_select_fuse ? 23'h000000 : BOOT_START_WORD))
		else $error("reset vector wrong");
	irq_mask_a: assert property (irq_suppress |-> $past(!lock_bits[1] &&
		cpu_pc < BOOT_START_WORD || !lock_bits[3] && cpu_pc >= BOOT_START_WORD))
		else $error("irq masked without cause");
	lock_rise_a: assert property (|(lock_bits & ~$past(lock_bits)) |->
		$past(prog_if_chip_erase) || $past(prog_if_chip_erase, 2))
		else $error("lock cleared without erase");
endmodule // fsp_monitor

bind fsp_top fsp_monitor #(
	.BOOT_START_WORD(BOOT_START_WORD),
	.PAGE_WORD_BITS(PAGE_WORD_BITS)
) mon (
	.pclk(pclk), .presetn(presetn), .cpu_pc(cpu_pc),
	.load_program_memory_instr(load_program_memory_instr),
	.store_program_memory_instr(store_program_memory_instr),
	.pointer_high_byte(pointer_high_byte), .pointer_low_byte(pointer_low_byte),
	.boot_reset_select_fuse(boot_reset_select_fuse), .prog_if_chip_erase(prog_if_chip_erase),
	.lpm_grant(lpm_grant), .lpm_deny(lpm_deny), .lpm_byte_addr(lpm_byte_addr),
	.byte_select_bit(byte_select_bit), .spm_grant(spm_grant), .spm_deny(spm_deny),
	.spm_busy(spm_busy), .spm_word_addr(spm_word_addr), .spm_page_num(spm_page_num),
	.spm_word_index(spm_word_index), .irq_suppress(irq_suppress),
	.reset_vector(reset_vector), .lock_bits(lock_bits)
);

// [tb/fsp_cpu_model.sv]
// core model: issues load and store strobes, answers flash completion
// assumes the same pclk as fsp_top
`timescale 1ns/1ns
module fsp_cpu_model #(
	parameter int DONE_DLY = 6
) (
	input wire logic pclk,
	input wire logic spm_busy,
	output logic [22:0] cpu_pc,
	output logic        load_program_memory_instr,
	output logic        store_program_memory_instr,
	output logic [7:0]  pointer_high_byte,
	output logic [7:0]  pointer_low_byte,
	output logic        flash_op_done
);
	int cnt;
	initial begin
		{cpu_pc, load_program_memory_instr, store_program_memory_instr} = '0;
		{pointer_high_byte, pointer_low_byte} = '0;
	end
	// ====
	// flash completion some cycles into each operation
	always @(posedge pclk) begin
		cnt <= spm_busy ? cnt + 1 : 0;
		flash_op_done <= spm_busy && cnt == DONE_DLY;
	end
	// ====
	// one instruction: 0 moves pc and pointer with no strobe, 1 load, 2 store; both pointer bytes per op, extension left as set
	task automatic issue(input int k, input logic [22:0] pc, input logic [15:0] p);
		@(posedge pclk);
		cpu_pc <= pc;
		{pointer_high_byte, pointer_low_byte} <= p;
		load_program_memory_instr <= (k == 1);
		store_program_memory_instr <= (k == 2);
		@(posedge pclk);
		{load_program_memory_instr, store_program_memory_instr} <= 2'b00;
		@(negedge pclk);
	endtask
endmodule // fsp_cpu_model

// [tb/fsp_top_tb.sv]
// testbench for fsp_top: apb registers and core access checks
// assumes fsp_cpu_model on the core side and fsp_monitor bound in
`timescale 1ns/1ns
`include "fsp_defines.svh"
module fsp_top_tb;
	localparam logic [22:0] BOOT = 23'h000400;
	localparam logic [22:0] PA = 23'h000010;
	localparam logic [22:0] PB = 23'h000500;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [22:0] cpu_pc, spm_word_addr, reset_vector;
	logic        load_program_memory_instr, store_program_memory_instr;
	logic [7:0]  pointer_high_byte, pointer_low_byte;
	logic        flash_op_done, boot_reset_select_fuse, prog_if_lock_wr, prog_if_chip_erase;
	logic [3:0]  stored_lock_bits, prog_if_lock_data, lock_bits;
	logic        lpm_grant, lpm_deny, byte_select_bit, spm_grant, spm_deny, spm_busy;
	logic        irq_suppress;
	logic [23:0] lpm_byte_addr;
	logic [15:0] spm_page_num;
	logic [6:0]  spm_word_index;
	int          errors, tests_run, n;
	fsp_top #(.BOOT_START_WORD(BOOT)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_pc(cpu_pc), .load_program_memory_instr(load_program_memory_instr),
		.store_program_memory_instr(store_program_memory_instr),
		.pointer_high_byte(pointer_high_byte), .pointer_low_byte(pointer_low_byte),
		.flash_op_done(flash_op_done), .boot_reset_select_fuse(boot_reset_select_fuse),
		.stored_lock_bits(stored_lock_bits), .prog_if_lock_wr(prog_if_lock_wr),
		.prog_if_lock_data(prog_if_lock_data), .prog_if_chip_erase(prog_if_chip_erase),
		.lpm_grant(lpm_grant), .lpm_deny(lpm_deny), .lpm_byte_addr(lpm_byte_addr),
		.byte_select_bit(byte_select_bit), .spm_grant(spm_grant), .spm_deny(spm_deny),
		.spm_busy(spm_busy), .spm_word_addr(spm_word_addr), .spm_page_num(spm_page_num),
		.spm_word_index(spm_word_index), .irq_suppress(irq_suppress),
		.reset_vector(reset_vector), .lock_bits(lock_bits)
	);
	fsp_cpu_model cpu (
		.pclk(pclk), .spm_busy(spm_busy), .cpu_pc(cpu_pc),
		.load_program_memory_instr(load_program_memory_instr),
		.store_program_memory_instr(store_program_memory_instr),
		.pointer_high_byte(pointer_high_byte), .pointer_low_byte(pointer_low_byte),
		.flash_op_done(flash_op_done)
	);
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// ====
	// tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && n++ < 40);
		rd = prdata;
		er = pslverr;
		chk("pready", 1'b1, pready);
		{psel, penable} <= 2'b00;
	endtask
	task automatic op(input int k, input logic [22:0] pc, input logic [15:0] p, input logic dn);
		n = 0;
		while (spm_busy !== 1'b0 && n++ < 40) @(negedge pclk);
		chk("busy", 1'b0, spm_busy);
		cpu.issue(k, pc, p);
		if (k == 1) chk("load", {!dn, dn}, {lpm_grant, lpm_deny});
		else chk("store", {!dn, dn}, {spm_grant, spm_deny});
	endtask
	task automatic rst(input logic f, input logic [3:0] s);
		@(posedge pclk);
		{boot_reset_select_fuse, stored_lock_bits, presetn} <= {f, s, 1'b0};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic erase;
		@(posedge pclk);
		prog_if_chip_erase <= 1'b1;
		@(posedge pclk);
		prog_if_chip_erase <= 1'b0;
	endtask
	task automatic finish_test;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		finish_test();
	end
	// ====
	// main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		{prog_if_lock_wr, prog_if_lock_data, prog_if_chip_erase} = '0;
		{boot_reset_select_fuse, stored_lock_bits} = 5'h1f;
		errors = 0;
		tests_run = 0;
		rst(1'b1, 4'hf);
		chk("lock", 4'hf, lock_bits);
		chk("rvec", 23'h0, reset_vector);
		apb(1'b0, 12'h020, 0);
		chk("slverr", 1'b1, er);
		apb(1'b1, `FSP_OFF_PTR_EXT, 32'h1);
		apb(1'b0, `FSP_OFF_PTR_EXT, 0);
		chk("ext", 8'h01, rd[7:0]);
		op(1, PA, 16'h2345, 1'b0);
		chk("laddr", 24'h012345, lpm_byte_addr);
		chk("bsel", 1'b1, byte_select_bit);
		apb(1'b1, `FSP_OFF_PTR_EXT, 0);
		for (int i = 0; i < 16; i++) begin
			erase();
			apb(1'b1, `FSP_OFF_LOCK, i);
			apb(1'b1, `FSP_OFF_LOCK, 32'hf);
			apb(1'b0, `FSP_OFF_LOCK, 0);
			chk("lock_rd", i, rd[3:0]);
			op(1, PB, 16'h0040, !i[1]);
			op(1, PA, 16'h0a00, !i[3]);
			op(2, PB, 16'h0040, !i[0]);
			op(2, PB, 16'h0a00, !i[2]);
			apb(1'b1, `FSP_OFF_CFG, 32'h1);
			cpu.issue(0, PA, 0);
			chk("irq_app", !i[1], irq_suppress);
			apb(1'b1, `FSP_OFF_CFG, 0);
			cpu.issue(0, PB, 0);
			chk("irq_boot", !i[3], irq_suppress);
		end
		apb(1'b0, `FSP_OFF_CFG, 0);
		chk("fuse_ro", 1'b1, rd[1]);
		erase();
		op(2, PB, 16'h0904, 1'b0);
		cpu.issue(2, PB, 16'h0a00);
		chk("busy_deny", 1'b1, spm_deny);
		chk("tgt", 23'h000482, spm_word_addr);
		chk("page", 16'h0009, spm_page_num);
		chk("idx", 7'h02, spm_word_index);
		op(2, PA, 16'h0040, 1'b1);
		apb(1'b0, `FSP_OFF_STATUS, 0);
		chk("status", 32'h0000001f, rd);
		apb(1'b1, `FSP_OFF_STATUS, 32'h1f);
		apb(1'b0, `FSP_OFF_STATUS, 0);
		chk("status_clr", 32'h00000000, rd);
		apb(1'b0, `FSP_OFF_TARGET, 0);
		chk("tgt_reg", 32'h00000482, rd);
		apb(1'b0, `FSP_OFF_RESET_VEC, 0);
		chk("rvec_reg", 32'h00000000, rd);
		@(posedge pclk);
		{prog_if_lock_wr, prog_if_lock_data} <= 5'h1b;
		@(posedge pclk);
		prog_if_lock_wr <= 1'b0;
		repeat (2) @(negedge pclk);
		chk("pif_lock", 4'hb, lock_bits);
		rst(1'b0, 4'h7);
		chk("rvec_boot", BOOT, reset_vector);
		chk("lock_init", 4'h7, lock_bits);
		finish_test();
	end
endmodule // fsp_top_tb
